/* verilog/rlpv_verifier.sv */
// rlpv_verifier: four-lane receive pattern verifier with its registers
// assumes: rx_lane_bit carries one recovered bit per lane per clock,
// asynchronous to clk; register port driven by logic on clk
//
// Function
// - timing pulse lasts 8 UI per pattern cycle; clock source (2 UI cycle) holds it high
// - load high applies live settings to lane
// - load falling edge freezes lane settings
// - mismatch flags read in bits 7:4
// - search flags read in bits 3:0
// - custom length bit picks 16 or 20
// - prbs length field picks the polynomial
// - source field picks off, prbs, clock, custom
// - source 1xx gives timing-only sync pulses
// - custom word low byte at 11h
// - custom word bits 15:8 at 12h, 19:16 at 13h
`timescale 1ns/1ps
`default_nettype none
`include "rlpv_cfg.svh"

module rlpv_verifier
    import rlpv_pkg::*;
#(
    parameter int LANES = `RLPV_LANES
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr_en,
    input  wire logic [7:0]        reg_wr_data,
    output logic [7:0]             reg_rd_data,
    // recovered serial data, one bit per lane
    input  wire logic [LANES-1:0]  rx_lane_bit,
    // timeout setting from the device's own control logic
    input  wire logic [3:0]        verifier_timeout_setting,
    // per-lane status
    output wire logic [LANES-1:0]  lane_timing_pulse,
    output wire logic [LANES-1:0]  lane_mismatch_flag,
    output wire logic [LANES-1:0]  lane_search_active
);

    // the status fields are four bits wide, so more lanes cannot be read
    if (LANES < 1 || LANES > `RLPV_LANES)
        $error("rlpv_verifier: LANES must lie between 1 and 4");

    // shared settings registers
    logic [LANES-1:0] lane_settings_load;       // per-lane load bits
    logic             custom_length_select;     // 0 = 16, 1 = 20 bits
    logic [2:0]       prbs_length_select;       // polynomial code
    logic [2:0]       pattern_source_select;    // reference code
    logic [19:0]      custom_reference_word;    // custom word
    logic [LANES-1:0] next_load;
    logic             next_cp20;
    logic [2:0]       next_len;
    logic [2:0]       next_sel;
    logic [19:0]      next_word;
    logic [7:0]       next_rd_data;
    rlpv_cfg_type     live_cfg;                 // settings as written

    // two-flop synchroniser for the recovered bits
    logic [LANES-1:0] rx_meta;
    logic [LANES-1:0] rx_sync;

    // status fields widened to four bits for read back
    logic [3:0] pulse_rd;
    logic [3:0] fail_rd;
    logic [3:0] tip_rd;

    assign live_cfg = '{timeout:  verifier_timeout_setting,
                        source:   pattern_source_select,
                        prbs_len: prbs_length_select,
                        cust20:   custom_length_select,
                        word:     custom_reference_word};

    // rx pins are asynchronous; only rx_sync is read downstream
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_meta <= '0;
            rx_sync <= '0;
        end
        else
        begin
            rx_meta <= rx_lane_bit;
            rx_sync <= rx_meta;
        end
    end

    // register writes and read-back selection
    always_comb
    begin
        next_load = lane_settings_load;
        next_cp20 = custom_length_select;
        next_len  = prbs_length_select;
        next_sel  = pattern_source_select;
        next_word = custom_reference_word;
        pulse_rd  = 4'(lane_timing_pulse);
        fail_rd   = 4'(lane_mismatch_flag);
        tip_rd    = 4'(lane_search_active);
        if (reg_wr_en)
        begin
            // upper nibbles of 0e and 13h are read-only
            if (reg_addr == `RLPV_OFF_LOAD)
                next_load = reg_wr_data[`RLPV_LOAD_LSB +: LANES];
            else if (reg_addr == `RLPV_OFF_CFG)
            begin
                next_cp20 = reg_wr_data[`RLPV_CP20_BIT];
                next_len  = reg_wr_data[`RLPV_LEN_LSB +: 3];
                next_sel  = reg_wr_data[`RLPV_SEL_LSB +: 3];
            end
            else if (reg_addr == `RLPV_OFF_WLO)
                next_word[7:0] = reg_wr_data;
            else if (reg_addr == `RLPV_OFF_WMID)
                next_word[15:8] = reg_wr_data;
            else if (reg_addr == `RLPV_OFF_WHI)
                next_word[19:16] = reg_wr_data[3:0];
        end
        // read data reflects the address one clock earlier
        if (reg_addr == `RLPV_OFF_LOAD)
            next_rd_data = {pulse_rd, 4'(lane_settings_load)};
        else if (reg_addr == `RLPV_OFF_STAT)
            next_rd_data = {fail_rd, tip_rd};
        else if (reg_addr == `RLPV_OFF_CFG)
            next_rd_data = {custom_length_select, 1'b0,
                            prbs_length_select, pattern_source_select};
        else if (reg_addr == `RLPV_OFF_WLO)
            next_rd_data = custom_reference_word[7:0];
        else if (reg_addr == `RLPV_OFF_WMID)
            next_rd_data = custom_reference_word[15:8];
        else if (reg_addr == `RLPV_OFF_WHI)
            next_rd_data = {4'h0, custom_reference_word[19:16]};
        else
            next_rd_data = `RLPV_RST_BYTE;      // unmapped reads zero
    end

    // settings and read data registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lane_settings_load    <= '0;
            custom_length_select  <= 1'b0;
            prbs_length_select    <= `RLPV_RST_LEN;
            pattern_source_select <= `RLPV_RST_SEL;
            custom_reference_word <= `RLPV_RST_WORD;
            reg_rd_data           <= `RLPV_RST_BYTE;
        end
        else
        begin
            lane_settings_load    <= next_load;
            custom_length_select  <= next_cp20;
            prbs_length_select    <= next_len;
            pattern_source_select <= next_sel;
            custom_reference_word <= next_word;
            reg_rd_data           <= next_rd_data;
        end
    end

    // one checker per lane
    for (genvar g = 0; g < LANES; g++)
    begin : lane
        rlpv_cfg_type           held_cfg;   // settings frozen at load fall
        rlpv_cfg_type           cfg;        // settings in force
        rlpv_state_type         state;
        logic [`RLPV_HIST_W-1:0] hist;      // received history, newest at 0
        logic [7:0]             run;        // consecutive good predictions
        logic [4:0]             idx;        // custom word bit expected
        logic [31:0]            cyc;        // position in pattern cycle
        logic                   pulse;
        logic                   fail;
        logic                   tip;
        rlpv_cfg_type           next_held;
        rlpv_state_type         next_state;
        logic [`RLPV_HIST_W-1:0] next_hist;
        logic [7:0]             next_run;
        logic [4:0]             next_idx;
        logic [31:0]            next_cyc;
        logic                   next_pulse;
        logic                   next_fail;
        logic                   next_tip;
        logic                   pred;
        logic [31:0]            period;
        logic                   custom_hit;
        logic [7:0]             lock_run;
        logic                   rx;
        logic                   checking;
        logic                   bit_err;

        assign rx = rx_sync[g];
        // while load is high the live settings pass straight through
        assign cfg = lane_settings_load[g] ? live_cfg : held_cfg;

        rlpv_lane_ref u_ref (
            .cfg        (cfg),
            .hist       (hist),
            .rx_bit     (rx),
            .idx        (idx),
            .pred       (pred),
            .period     (period),
            .custom_hit (custom_hit),
            .lock_run   (lock_run)
        );

        // search, lock and cycle tracking for this lane
        always_comb
        begin
            checking  = (cfg.source != rlpv_src_off) && !cfg.source[2];
            bit_err   = rx != pred;
            // held copy tracks live while loading, so the fall keeps it
            next_held = lane_settings_load[g] ? live_cfg : held_cfg;
            next_hist = {hist[`RLPV_HIST_W-2:0], rx};
            next_state = state;
            next_run   = run;
            next_idx   = idx;
            next_fail  = fail;
            // pattern cycle counter wraps at the period
            if (period == 32'h0000_0000 || cyc >= period - 32'h0000_0001)
                next_cyc = 32'h0000_0000;
            else
                next_cyc = cyc + 32'h0000_0001;
            if (lane_settings_load[g])
            begin
                // reloading restarts the search and clears the flag
                next_state = checking ? rlpv_st_search : rlpv_st_idle;
                next_run   = 8'h00;
                next_idx   = 5'h00;
                next_fail  = 1'b0;
                next_cyc   = 32'h0000_0000;
            end
            else
            begin
                case (state)
                    rlpv_st_search:
                    begin
                        if (cfg.source == rlpv_src_cust)
                        begin
                            // word seen whole: next bit is its msb
                            if (custom_hit)
                            begin
                                next_state = rlpv_st_lock;
                                next_idx = cfg.cust20 ? 5'd19 : 5'd15;
                            end
                        end
                        else if (bit_err)
                            next_run = 8'h00;
                        else if (run + 8'h01 >= lock_run)
                            next_state = rlpv_st_lock;
                        else
                            next_run = run + 8'h01;
                    end
                    rlpv_st_lock:
                    begin
                        if (bit_err)
                            next_fail = 1'b1;
                        if (idx == 5'd0)
                            next_idx = cfg.cust20 ? 5'd19 : 5'd15;
                        else
                            next_idx = idx - 5'd1;
                    end
                    default:
                        next_state = rlpv_st_idle;
                endcase
            end
            // disabled lanes never report a mismatch or a timing pulse
            if (cfg.source == rlpv_src_off)
            begin
                next_fail = 1'b0;
                next_pulse = 1'b0;
            end
            else
                next_pulse = next_cyc < 32'(`RLPV_PULSE_UI);
            next_tip = next_state == rlpv_st_search;
        end

        // lane state registers
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                held_cfg <= '0;
                state    <= rlpv_st_idle;
                hist     <= '0;
                run      <= 8'h00;
                idx      <= 5'h00;
                cyc      <= 32'h0000_0000;
                pulse    <= 1'b0;
                fail     <= 1'b0;
                tip      <= 1'b0;
            end
            else
            begin
                held_cfg <= next_held;
                state    <= next_state;
                hist     <= next_hist;
                run      <= next_run;
                idx      <= next_idx;
                cyc      <= next_cyc;
                pulse    <= next_pulse;
                fail     <= next_fail;
                tip      <= next_tip;
            end
        end

        assign lane_timing_pulse[g]  = pulse;
        assign lane_mismatch_flag[g] = fail;
        assign lane_search_active[g] = tip;
    end

endmodule // rlpv_verifier
`default_nettype wire

/* verilog/rlpv_cfg.svh */
// rlpv_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the verifier and lane reference design files
`ifndef RLPV_CFG_SVH
`define RLPV_CFG_SVH

// lane count and history depth
`define RLPV_LANES        4
`define RLPV_HIST_W       31

// register offsets
`define RLPV_OFF_LOAD     8'h0e
`define RLPV_OFF_STAT     8'h0f
`define RLPV_OFF_CFG      8'h10
`define RLPV_OFF_WLO      8'h11
`define RLPV_OFF_WMID     8'h12
`define RLPV_OFF_WHI      8'h13

// field positions
`define RLPV_SYNC_LSB     4
`define RLPV_LOAD_LSB     0
`define RLPV_FAIL_LSB     4
`define RLPV_TIP_LSB      0
`define RLPV_CP20_BIT     7
`define RLPV_LEN_LSB      3
`define RLPV_SEL_LSB      0

// reset values
`define RLPV_RST_BYTE     8'h00
`define RLPV_RST_WORD     20'h0_0000
`define RLPV_RST_LEN      3'h0
`define RLPV_RST_SEL      3'h0

// timing, one unit interval per clock
`define RLPV_PULSE_UI     8
`define RLPV_LOCK_STEP    8
`define RLPV_LOCK_BASE    32

`endif

/* verilog/rlpv_pkg.sv */
// rlpv_pkg: types shared by the pattern verifier files
// assumes: rlpv_cfg.svh supplies the numeric constants
package rlpv_pkg;

    // verifier reference selection, 1xx means timing only
    typedef enum logic [2:0] {
        rlpv_src_off  = 3'b000,
        rlpv_src_prbs = 3'b001,
        rlpv_src_clk  = 3'b010,
        rlpv_src_cust = 3'b011
    } rlpv_src_type;

    // per-lane checker state
    typedef enum logic [1:0] {
        rlpv_st_idle   = 2'b00,
        rlpv_st_search = 2'b01,
        rlpv_st_lock   = 2'b10
    } rlpv_state_type;

    // settings applied to one lane
    typedef struct packed {
        logic [3:0]  timeout;
        logic [2:0]  source;
        logic [2:0]  prbs_len;
        logic        cust20;
        logic [19:0] word;
    } rlpv_cfg_type;

endpackage

/* verilog/rlpv_lane_ref.sv */
// rlpv_lane_ref: reference bit, pattern period and lock figures for a lane
// assumes: purely combinational, fed from registered lane state
`timescale 1ns/1ps
`default_nettype none
`include "rlpv_cfg.svh"

module rlpv_lane_ref
    import rlpv_pkg::*;
(
    // lane settings and history
    input  wire rlpv_cfg_type             cfg,
    input  wire logic [`RLPV_HIST_W-1:0]  hist,
    input  wire logic                     rx_bit,
    input  wire logic [4:0]               idx,
    // derived values
    output logic                          pred,
    output logic [31:0]                   period,
    output logic                          custom_hit,
    output logic [7:0]                    lock_run
);

    logic [4:0]  tap_n;    // polynomial degree
    logic [4:0]  tap_m;    // inner tap
    logic [19:0] win;      // newest twenty received bits
    logic [19:0] mask;     // custom word length mask

    // polynomial choice and prediction per source
    always_comb
    begin
        case (cfg.prbs_len)
            3'b000:  {tap_n, tap_m} = {5'd7, 5'd6};
            3'b001:  {tap_n, tap_m} = {5'd11, 5'd9};
            3'b010:  {tap_n, tap_m} = {5'd23, 5'd18};
            3'b011:  {tap_n, tap_m} = {5'd31, 5'd28};
            3'b100,
            3'b101:  {tap_n, tap_m} = {5'd15, 5'd14};
            default: {tap_n, tap_m} = {5'd20, 5'd17};
        endcase
        win  = {hist[18:0], rx_bit};
        // upper nibble joins only in 20-bit mode
        mask = cfg.cust20 ? 20'hf_ffff : 20'h0_ffff;
        custom_hit = ((win ^ cfg.word) & mask) == 20'h0_0000;
        lock_run = 8'(`RLPV_LOCK_BASE
                   + (int'(cfg.timeout) + 1) * `RLPV_LOCK_STEP);
        pred   = 1'b0;
        period = 32'h0000_0000;
        case (cfg.source)
            rlpv_src_prbs:
            begin
                // self-synchronising: predict from received history
                pred   = hist[tap_n - 5'd1] ^ hist[tap_m - 5'd1];
                period = (32'h0000_0001 << tap_n) - 32'h0000_0001;
            end
            rlpv_src_clk:
            begin
                pred   = ~hist[0];
                period = 32'h0000_0002;
            end
            rlpv_src_cust:
            begin
                pred   = cfg.word[idx];
                period = cfg.cust20 ? 32'h0000_0014 : 32'h0000_0010;
            end
            default:
            begin
                // timing-only spacing follows the prbs length
                if (cfg.source[2])
                    period = (32'h0000_0001 << tap_n) - 32'h0000_0001;
            end
        endcase
    end

endmodule // rlpv_lane_ref
`default_nettype wire

/* verification/rlpv_verifier_sva.sv */
// rlpv_verifier_sva: port-level checks of the pattern verifier
// assumes: lane 0 settings are tracked from register writes
`timescale 1ns/1ps
`default_nettype none

module rlpv_verifier_sva
#(
    parameter int LANES = 4
)
(
    // clock and reset
    input wire logic             clk,
    input wire logic             rst_b,
    // register port
    input wire logic [7:0]       reg_addr,
    input wire logic             reg_wr_en,
    input wire logic [7:0]       reg_wr_data,
    input wire logic [7:0]       reg_rd_data,
    // lane side
    input wire logic [LANES-1:0] rx_lane_bit,
    input wire logic [3:0]       verifier_timeout_setting,
    input wire logic [LANES-1:0] lane_timing_pulse,
    input wire logic [LANES-1:0] lane_mismatch_flag,
    input wire logic [LANES-1:0] lane_search_active
);
    logic [3:0] load_sh, next_load_sh; // shadow of the load bits
    logic [2:0] cfg_sh, next_cfg_sh;   // shadow of the source field
    logic [2:0] src0, next_src0;       // source lane 0 really holds
    logic [7:0] stat_v;                // status byte as mapped
    logic       p0, f0, s0;            // lane 0 outputs

    // each half padded on its own so narrow builds keep the field split
    assign stat_v = {4'(lane_mismatch_flag), 4'(lane_search_active)};
    assign p0 = lane_timing_pulse[0];
    assign f0 = lane_mismatch_flag[0];
    assign s0 = lane_search_active[0];

    // lane 0 follows the live field only while its load bit is up
    always_comb
    begin
        next_load_sh = load_sh;
        next_cfg_sh  = cfg_sh;
        if (reg_wr_en && reg_addr == 8'h0e)
            next_load_sh = reg_wr_data[3:0];
        if (reg_wr_en && reg_addr == 8'h10)
            next_cfg_sh = reg_wr_data[2:0];
        next_src0 = load_sh[0] ? cfg_sh : src0;
    end

    // shadow registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            load_sh <= 4'h0;
            cfg_sh  <= 3'h0;
            src0    <= 3'h0;
        end
        else
        begin
            load_sh <= next_load_sh;
            cfg_sh  <= next_cfg_sh;
            src0    <= next_src0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_low_write;
        reg_wr_en && reg_addr == 8'h11;
    endsequence
    sequence s_src_off;
        src0 == 3'h0;
    endsequence
    sequence s_pulse_run;
        p0 [*8] ##1 !p0;
    endsequence

    a_status_read: assert property (reg_addr == 8'h0f |=>
        reg_rd_data == $past(stat_v)) else $error("status byte wrong");
    a_low_readback: assert property (s_low_write ##1 reg_addr == 8'h11
        |=> reg_rd_data == $past(reg_wr_data, 2)) else $error("low byte");
    a_reserved_zero: assert property (reg_addr == 8'h13
        |=> reg_rd_data[7:4] == 4'h0) else $error("reserved bits set");
    a_pulse_width: assert property ($rose(p0) && src0 != 3'h2
        |-> s_pulse_run or ##[0:9] load_sh[0]) else $error("pulse width");
    a_off_quiet: assert property (s_src_off [*3] |->
        !p0 && !f0 && !s0) else $error("disabled lane active");
    a_timing_quiet: assert property (src0[2] [*3] |->
        !f0 && !s0) else $error("timing-only lane checks");
    a_search_load: assert property ($fell(load_sh[0]) && src0 == 3'h1
        |-> s0) else $error("no search after load");
    a_fail_sticky: assert property (f0 && !load_sh[0] |=> f0)
        else $error("mismatch flag dropped");
    a_fail_locked: assert property ($rose(f0) |-> !s0)
        else $error("mismatch while searching");
endmodule // rlpv_verifier_sva

bind rlpv_verifier rlpv_verifier_sva #(.LANES(LANES)) sva_u (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .rx_lane_bit(rx_lane_bit),
    .verifier_timeout_setting(verifier_timeout_setting),
    .lane_timing_pulse(lane_timing_pulse),
    .lane_mismatch_flag(lane_mismatch_flag),
    .lane_search_active(lane_search_active));

`default_nettype wire

/* verification/rlpv_src_model.sv */
// rlpv_src_model: upstream source sending test patterns on four lanes
// assumes: one bit per lane per clock, updated on the rising edge
`timescale 1ns/1ps
`default_nettype none

module rlpv_src_model
(
    // pattern control from the bench
    input  wire logic        clk,
    input  wire logic [1:0]  mode,
    input  wire logic [19:0] word,
    input  wire logic        len20,
    input  wire logic [3:0]  flip,
    // serial bits toward the receiver
    output logic [3:0]       rx = 4'h0
);
    logic [6:0] lfsr = 7'h7f; // prbs7 state, never all zero
    logic [4:0] pos = 5'h00;  // custom word bit index
    logic [4:0] top;          // last index of the custom word
    logic       nb;           // next bit sent

    assign top = len20 ? 5'h13 : 5'h0f;

    // 0 prbs7, 1 clock, 2 custom word msb first; flip corrupts lanes
    always @(posedge clk)
    begin
        case (mode)
            2'h0: nb = lfsr[6] ^ lfsr[5];
            2'h1: nb = ~rx[1];
            default: nb = word[top - pos];
        endcase
        lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
        pos <= (pos == top) ? 5'h00 : pos + 5'h01;
        rx <= {4{nb}} ^ flip;
    end
endmodule // rlpv_src_model

`default_nettype wire

/* verification/rlpv_verifier_bench.sv */
// rlpv_verifier_bench: register-level tests of the pattern verifier
// assumes: rlpv_src_model feeds all lanes on the rising edge, other inputs change on falling edge
`timescale 1ns/1ps
`default_nettype none

module rlpv_verifier_bench
    import rlpv_pkg::*;
;
    logic        clk = 1'b0;         // 10 MHz clock
    logic        rst_b = 1'b0;       // active-low reset
    logic [7:0]  reg_addr = 8'h00;   // register port
    logic        reg_wr_en = 1'b0;
    logic [7:0]  reg_wr_data = 8'h00;
    logic [7:0]  reg_rd_data;
    logic [3:0]  rx_bits;            // serial lanes
    logic [3:0]  tmo = 4'h0;         // timeout setting
    logic [3:0]  pulse, fail, search; // lane status
    logic [1:0]  mode = 2'h0;        // source pattern kind
    logic [19:0] word = 20'h0_a5c3;  // custom word sent
    logic        len20 = 1'b0;
    logic [3:0]  flip = 4'h0;        // lanes to corrupt
    int          err_count = 0;
    int          n_checks = 0;
    int          n [2];              // lock times

    initial
    begin
        forever #50 clk = ~clk;
    end

    rlpv_verifier #(.LANES(4)) dut_u (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .rx_lane_bit(rx_bits),
        .verifier_timeout_setting(tmo), .lane_timing_pulse(pulse),
        .lane_mismatch_flag(fail), .lane_search_active(search));

    rlpv_src_model src_u (.clk(clk), .mode(mode), .word(word),
        .len20(len20), .flip(flip), .rx(rx_bits));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // an idle cycle follows so the strobe is never raised twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        @(negedge clk);
    endtask

    // read data is registered, so it is looked at one cycle later
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        @(negedge clk);
        chk({4'h0, reg_rd_data}, {4'h0, exp});
    endtask

    // load every lane: high for two cycles, then low
    task automatic ldall();
        wr(8'h0e, 8'h0f);
        wr(8'h0e, 8'h00);
    endtask

    // bounded wait for lane 0 to lock or to flag a mismatch
    task automatic wait_lane(input bit for_fail, output int c);
        c = 0;
        while ((for_fail ? fail[0] !== 1'b1 : search[0] !== 1'b0)
               && c < 400)
        begin
            @(negedge clk);
            c++;
        end
        if (c >= 400)
        begin
            err_count++;
            print_verdict();
        end
    endtask

    // high cycles of lane 0 pulse within a window of one period
    task automatic pulses(input int len, input int exp);
        int c;
        c = 0;
        repeat (len)
        begin
            @(negedge clk);
            c += pulse[0];
        end
        chk(12'(c), 12'(exp));
    endtask

    initial
    begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        for (int a = 14; a <= 19; a++)
            rdc(8'(a), 8'h00);
        wr(8'h11, 8'hc3);
        rdc(8'h11, 8'hc3);
        wr(8'h12, 8'ha5);
        rdc(8'h12, 8'ha5);
        wr(8'h13, 8'hff);
        rdc(8'h13, 8'h0f);
        wr(8'h10, 8'hff);
        rdc(8'h10, 8'hbf);
        wr(8'h0f, 8'hff);
        rdc(8'h0f, 8'h00);
        wr(8'h20, 8'h5a);
        rdc(8'h20, 8'h00);
        $display("test registers done");
        // lock time must grow by one step per timeout count
        wr(8'h10, 8'h01);
        for (int t = 0; t < 2; t++)
        begin
            tmo = 4'(t);
            ldall();
            rdc(8'h0f, 8'h0f);
            wait_lane(1'b0, n[t]);
        end
        chk(12'(n[1] - n[0]), 12'h008);
        wr(8'h10, 8'h00);
        pulses(127, 8);
        rdc(8'h0f, 8'h00);
        flip = 4'h1;
        @(negedge clk);
        flip = 4'h0;
        wait_lane(1'b1, n[0]);
        rdc(8'h0f, 8'h10);
        repeat (20) @(negedge clk);
        rdc(8'h0f, 8'h10);
        $display("test prbs done");
        mode = 2'h2;
        wr(8'h10, 8'h03);
        ldall();
        wait_lane(1'b0, n[0]);
        rdc(8'h0f, 8'h00);
        pulses(16, 8);
        word = 20'h9_a5c3;
        len20 = 1'b1;
        wr(8'h13, 8'h09);
        wr(8'h10, 8'h83);
        ldall();
        wait_lane(1'b0, n[0]);
        rdc(8'h0f, 8'h00);
        pulses(20, 8);
        $display("test custom done");
        mode = 2'h1;
        wr(8'h10, 8'h02);
        ldall();
        wait_lane(1'b0, n[0]);
        rdc(8'h0f, 8'h00);
        rdc(8'h0e, 8'hf0);
        wr(8'h10, 8'h04);
        ldall();
        pulses(127, 8);
        rdc(8'h0f, 8'h00);
        wr(8'h10, 8'h0f);
        ldall();
        pulses(2047, 8);
        wr(8'h10, 8'h2c);
        ldall();
        pulses(32767, 8);
        wr(8'h10, 8'h00);
        ldall();
        pulses(127, 0);
        rdc(8'h0f, 8'h00);
        $display("test modes done");
        print_verdict();
    end
endmodule // rlpv_verifier_bench

`default_nettype wire
